// [dpm_params.svh]
// Purpose: Offsets, field positions, reset values and timing figures of the dual-port memory port controller.
// Assumes: 100 MHz controller clock and the slowest speed grade of the memory.
// Notes: Times are in ns; cycle counts are derived in the controller.
`ifndef DPM_PARAMS_SVH
`define DPM_PARAMS_SVH

`define DPM_ADDR_W 15
`define DPM_DATA_W 9
`define DPM_SEM_SEL_W 3
`define DPM_MBOX_RIGHT 15'h7fff
`define DPM_MBOX_LEFT 15'h7ffe

`define REG_CTRL 8'h00
`define REG_CMD 8'h04
`define REG_ADDR 8'h08
`define REG_WDATA 8'h0c
`define REG_STATUS 8'h10
`define REG_RDATA 8'h14

`define CTRL_INT_EN_BIT 0
`define CTRL_ABORT_BIT 1
`define STAT_ACTIVE_BIT 0
`define STAT_DONE_BIT 1
`define STAT_OWNED_BIT 2
`define STAT_INT_BIT 3
`define STAT_BUSY_SEEN_BIT 4
`define STAT_DROPPED_BIT 5
`define STAT_RETRY_LSB 8
`define CTRL_RESET 1'b0

`define OP_NONE 3'h0
`define OP_MEM_RD 3'h1
`define OP_MEM_WR 3'h2
`define OP_SEM_ACQ 3'h3
`define OP_SEM_REL 3'h4
`define OP_MBX_SEND 3'h5
`define OP_MBX_READ 3'h6

`define CLK_PERIOD_NS 10
`define BUSY_AFTER_MATCH_DELAY_NS 20
`define BUSY_AFTER_SELECT_DELAY_NS 20
`define WRITE_PULSE_NS 15
`define ACCESS_TIME_NS 20
`define OUTPUT_DRIVE_ACCESS_TIME_NS 12
`define CYCLE_GAP_NS 20
`define FLAG_WRITE_RECOVERY_TIME_NS 10
`define FLAG_WRITE_TO_READ_DELAY_NS 10
`define SYNC_STAGES 2

`endif

// [dpm_pkg.sv]
// Purpose: Types shared by the dual-port memory port controller and its register slave.
// Assumes: dpm_params.svh supplies the widths and codes.
// Notes: Pin groups travel as packed structs.
`include "dpm_params.svh"

package dpm_pkg;

    typedef enum logic [2:0] {
        OP_NONE = `OP_NONE,
        OP_MEM_RD = `OP_MEM_RD,
        OP_MEM_WR = `OP_MEM_WR,
        OP_SEM_ACQ = `OP_SEM_ACQ,
        OP_SEM_REL = `OP_SEM_REL,
        OP_MBX_SEND = `OP_MBX_SEND,
        OP_MBX_READ = `OP_MBX_READ
    } op_e;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_SELECT = 5'h02,
        ST_WRITE = 5'h04,
        ST_READ = 5'h08,
        ST_RELEASE = 5'h10
    } ctl_state_e;

    // Pins driven toward one port of the memory; all selects are active low.
    typedef struct packed {
        logic ce_n;
        logic flag_latch_select_n;
        logic rw_n;
        logic oe_n;
        logic [`DPM_ADDR_W-1:0] addr;
        logic [`DPM_DATA_W-1:0] data_out;
        logic data_oe;
    } dpm_pins_s;

    // Pins read back from the memory port.
    typedef struct packed {
        logic int_n;
        logic busy_n;
        logic [`DPM_DATA_W-1:0] data_in;
    } dpm_in_s;

    // One register access handed from the bus slave to the controller.
    typedef struct packed {
        logic en;
        logic [7:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } reg_wr_s;

endpackage

// [axil_regslave.sv]
// Purpose: AXI4-Lite slave that turns bus transfers into single register accesses.
// Assumes: One write and one read at a time; the owner decodes addresses combinationally.
// Notes: Write address and data are taken in either order; read answers come one cycle after the take, write answers two cycles after the last take.
`timescale 1ns/10ps

module axil_regslave
    import dpm_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    output reg_wr_s wr,
    input wire logic wr_ok,
    output logic [7:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_ok
);

    typedef struct packed {
        logic aw_have;
        logic w_have;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        reg_wr_s wr;
    } slv_s;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    slv_s q, d;

    assign s_awready = !q.aw_have && !q.bvalid;
    assign s_wready = !q.w_have && !q.bvalid;
    assign s_bvalid = q.bvalid;
    assign s_bresp = q.bresp;
    assign s_arready = !q.rvalid;
    assign s_rvalid = q.rvalid;
    assign s_rdata = q.rdata;
    assign s_rresp = q.rresp;
    assign wr = q.wr;
    assign rd_addr = s_araddr;

    always_comb begin
        d = q;
        d.wr.en = 1'b0;
        if (s_awvalid && s_awready) begin
            d.aw_have = 1'b1;
            d.awaddr = s_awaddr;
        end
        if (s_wvalid && s_wready) begin
            d.w_have = 1'b1;
            d.wdata = s_wdata;
            d.wstrb = s_wstrb;
        end
        if (q.aw_have && q.w_have) begin
            d.aw_have = 1'b0;
            d.w_have = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
            d.wr.en = wr_ok;
            d.wr.addr = q.awaddr;
            d.wr.data = q.wdata;
            d.wr.strb = q.wstrb;
        end
        if (q.bvalid && s_bready) begin
            d.bvalid = 1'b0;
        end
        if (s_arvalid && s_arready) begin
            d.rvalid = 1'b1;
            d.rdata = rd_ok ? rd_data : 32'h0000_0000;
            d.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (q.rvalid && s_rready) begin
            d.rvalid = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule // axil_regslave

// [dpm_port_ctrl.sv]
// Purpose: Controller that drives one port of an asynchronous dual-port memory with mailbox, busy and flag latches.
// Assumes: 100 MHz clock; memory pins are asynchronous and every input is synchronised by two flip-flops.
// Notes: Software issues commands through AXI4-Lite registers; one memory or flag operation runs at a time.
`timescale 1ns/10ps

// Behaviour
// - Without message passing the interrupt pin stays unused; a control bit gates it.
// - Writes wait until busy has settled after select or address match.
// - Request a flag by writing zero then reading; zero owns, one keeps polling.
// - After a flag write, deselect for the recovery time, then wait write-to-read plus access.
// - Writing one releases an owned flag or cancels a pending request.
// - Flag access uses its own select with chip select high; three address bits choose.
// - A flag read uses the flag select plus output enable, not chip select.
module dpm_port_ctrl
    import dpm_pkg::*;
#(
    parameter bit IS_RIGHT_PORT = 1'b0,
    parameter int FLAG_RECOVERY_NS = `FLAG_WRITE_RECOVERY_TIME_NS,
    parameter int FLAG_WR_RD_NS = `FLAG_WRITE_TO_READ_DELAY_NS
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    output dpm_pins_s mem_pins,
    input wire dpm_in_s mem_in
);

    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int max_int(input int a, input int b);
        return (a > b) ? a : b;
    endfunction

    localparam int SETTLE_CYC = ns_to_cyc(max_int(`BUSY_AFTER_MATCH_DELAY_NS, `BUSY_AFTER_SELECT_DELAY_NS))
        + `SYNC_STAGES;
    localparam int PULSE_CYC = ns_to_cyc(`WRITE_PULSE_NS);
    localparam int READ_CYC = ns_to_cyc(max_int(`ACCESS_TIME_NS, FLAG_WR_RD_NS + `OUTPUT_DRIVE_ACCESS_TIME_NS))
        + `SYNC_STAGES;
    localparam int GAP_CYC = ns_to_cyc(`CYCLE_GAP_NS);
    localparam int FLAG_REC_CYC = ns_to_cyc(FLAG_RECOVERY_NS);
    localparam logic [`DPM_ADDR_W-1:0] MBOX_OWN = IS_RIGHT_PORT ? `DPM_MBOX_RIGHT : `DPM_MBOX_LEFT;
    localparam logic [`DPM_ADDR_W-1:0] MBOX_OTHER = IS_RIGHT_PORT ? `DPM_MBOX_LEFT : `DPM_MBOX_RIGHT;

    // Refused at elaboration: every timing count must fit the 8-bit step counter.
    if (max_int(max_int(SETTLE_CYC, PULSE_CYC), max_int(READ_CYC, max_int(GAP_CYC, FLAG_REC_CYC)))
        > 255) begin : g_count_check
        $error("dpm_port_ctrl: a timing count does not fit the 8-bit counter");
    end

    typedef struct packed {
        ctl_state_e st;
        logic [7:0] cnt;
        op_e op;
        logic phase_read;
        logic again;
        logic [`DPM_ADDR_W-1:0] addr;
        logic [`DPM_DATA_W-1:0] wdata;
        logic [`DPM_DATA_W-1:0] rdata;
        logic int_en;
        logic abort;
        logic done;
        logic owned;
        logic busy_seen;
        logic dropped;
        logic [7:0] retries;
        dpm_pins_s pins;
        logic [`SYNC_STAGES-1:0] busy_sync;
        logic [`SYNC_STAGES-1:0] int_sync;
        logic [`DPM_DATA_W-1:0] data_s1;
        logic [`DPM_DATA_W-1:0] data_s2;
    } ctl_s;

    ctl_s q, d;
    reg_wr_s wr;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;

    function automatic logic reg_hit(input logic [7:0] a);
        return a == `REG_CTRL || a == `REG_CMD || a == `REG_ADDR || a == `REG_WDATA || a == `REG_STATUS
            || a == `REG_RDATA;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input reg_wr_s w);
        logic [31:0] m;
        m = {{8{w.strb[3]}}, {8{w.strb[2]}}, {8{w.strb[1]}}, {8{w.strb[0]}}};
        return (old & ~m) | (w.data & m);
    endfunction

    function automatic logic is_flag(input op_e op);
        return op == OP_SEM_ACQ || op == OP_SEM_REL;
    endfunction

    function automatic logic is_write(input op_e op, input logic phase_read);
        return op == OP_MEM_WR || op == OP_MBX_SEND || op == OP_SEM_REL || (op == OP_SEM_ACQ && !phase_read);
    endfunction

    // Idle pins: every select high and the data bus released.
    function automatic dpm_pins_s idle_pins(input dpm_pins_s p);
        dpm_pins_s r;
        r = p;
        r.ce_n = 1'b1;
        r.flag_latch_select_n = 1'b1;
        r.rw_n = 1'b1;
        r.oe_n = 1'b1;
        r.data_oe = 1'b0;
        return r;
    endfunction

    // Selects the memory word or the flag latch for the operation with read/write high.
    function automatic dpm_pins_s select_pins(input op_e op, input logic [`DPM_ADDR_W-1:0] a);
        dpm_pins_s r;
        r = '0;
        r.rw_n = 1'b1;
        r.oe_n = 1'b1;
        r.ce_n = is_flag(op);
        r.flag_latch_select_n = !is_flag(op);
        case (op)
            OP_MBX_SEND: r.addr = MBOX_OTHER;
            OP_MBX_READ: r.addr = MBOX_OWN;
            OP_SEM_ACQ, OP_SEM_REL: r.addr = {{(`DPM_ADDR_W-`DPM_SEM_SEL_W){1'b0}}, a[`DPM_SEM_SEL_W-1:0]};
            default: r.addr = a;
        endcase
        return r;
    endfunction

    axil_regslave u_regs (
        .clock(clock),
        .rst_n(rst_n),
        .s_awaddr(s_awaddr),
        .s_awvalid(s_awvalid),
        .s_awready(s_awready),
        .s_wdata(s_wdata),
        .s_wstrb(s_wstrb),
        .s_wvalid(s_wvalid),
        .s_wready(s_wready),
        .s_bresp(s_bresp),
        .s_bvalid(s_bvalid),
        .s_bready(s_bready),
        .s_araddr(s_araddr),
        .s_arvalid(s_arvalid),
        .s_arready(s_arready),
        .s_rdata(s_rdata),
        .s_rresp(s_rresp),
        .s_rvalid(s_rvalid),
        .s_rready(s_rready),
        .wr(wr),
        .wr_ok(reg_hit(u_regs.q.awaddr)),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_ok(reg_hit(rd_addr))
    );

    assign mem_pins = q.pins;

    always_comb begin
        rd_data = 32'h0000_0000;
        case (rd_addr)
            `REG_CTRL: rd_data[`CTRL_INT_EN_BIT] = q.int_en;
            `REG_ADDR: rd_data[`DPM_ADDR_W-1:0] = q.addr;
            `REG_WDATA: rd_data[`DPM_DATA_W-1:0] = q.wdata;
            `REG_RDATA: rd_data[`DPM_DATA_W-1:0] = q.rdata;
            `REG_STATUS: begin
                rd_data[`STAT_ACTIVE_BIT] = q.st != ST_IDLE;
                rd_data[`STAT_DONE_BIT] = q.done;
                rd_data[`STAT_OWNED_BIT] = q.owned;
                rd_data[`STAT_INT_BIT] = q.int_en && !q.int_sync[`SYNC_STAGES-1];
                rd_data[`STAT_BUSY_SEEN_BIT] = q.busy_seen;
                rd_data[`STAT_DROPPED_BIT] = q.dropped;
                rd_data[`STAT_RETRY_LSB +: 8] = q.retries;
            end
            default: rd_data = 32'h0000_0000;
        endcase
    end

    always_comb begin
        logic [31:0] m;
        m = 32'h0000_0000;
        d = q;
        d.busy_sync = {q.busy_sync[`SYNC_STAGES-2:0], mem_in.busy_n};
        d.int_sync = {q.int_sync[`SYNC_STAGES-2:0], mem_in.int_n};
        d.data_s1 = mem_in.data_in;
        d.data_s2 = q.data_s1;

        // Software side; hardware sets below are placed after, so a set wins over a clear.
        if (wr.en) begin
            case (wr.addr)
                `REG_CTRL: begin
                    m = merge({31'h0000_0000, q.int_en}, wr);
                    d.int_en = m[`CTRL_INT_EN_BIT];
                    d.abort = q.abort || (m[`CTRL_ABORT_BIT] && q.st != ST_IDLE);
                end
                `REG_ADDR: begin
                    m = merge({17'h0_0000, q.addr}, wr);
                    d.addr = m[`DPM_ADDR_W-1:0];
                end
                `REG_WDATA: begin
                    m = merge({23'h00_0000, q.wdata}, wr);
                    d.wdata = m[`DPM_DATA_W-1:0];
                end
                `REG_STATUS: begin
                    if (wr.strb[0] && wr.data[`STAT_DONE_BIT]) d.done = 1'b0;
                    if (wr.strb[0] && wr.data[`STAT_BUSY_SEEN_BIT]) d.busy_seen = 1'b0;
                    if (wr.strb[0] && wr.data[`STAT_DROPPED_BIT]) d.dropped = 1'b0;
                end
                `REG_CMD: begin
                    if (q.st == ST_IDLE && wr.strb[0] && wr.data[2:0] != `OP_NONE && wr.data[2:0] <= `OP_MBX_READ) begin
                        d.op = op_e'(wr.data[2:0]);
                        d.phase_read = 1'b0;
                        d.retries = 8'h00;
                        d.pins = select_pins(op_e'(wr.data[2:0]), q.addr);
                        d.cnt = 8'(SETTLE_CYC);
                        d.st = ST_SELECT;
                    end else begin
                        d.dropped = 1'b1;
                    end
                end
                default: d.dropped = q.dropped;
            endcase
        end

        case (q.st)
            ST_IDLE: begin
                d.abort = 1'b0;
            end
            ST_SELECT: begin
                if (q.cnt != 8'h00) begin
                    d.cnt = q.cnt - 8'h01;
                end else if (!is_flag(q.op) && !q.busy_sync[`SYNC_STAGES-1]) begin
                    // Lost arbitration: back off and retry, so a blocked access has no effect.
                    d.busy_seen = 1'b1;
                    d.retries = (q.retries == 8'hff) ? q.retries : q.retries + 8'h01;
                    d.pins = idle_pins(q.pins);
                    d.again = 1'b1;
                    d.cnt = 8'(GAP_CYC);
                    d.st = ST_RELEASE;
                end else if (is_write(q.op, q.phase_read)) begin
                    // Busy has settled before the write strobe, as a slave memory needs.
                    d.pins.rw_n = 1'b0;
                    d.pins.data_oe = 1'b1;
                    case (q.op)
                        OP_SEM_ACQ: d.pins.data_out = '0;
                        OP_SEM_REL: d.pins.data_out = '1;
                        default: d.pins.data_out = q.wdata;
                    endcase
                    d.cnt = 8'(PULSE_CYC);
                    d.st = ST_WRITE;
                end else begin
                    d.pins.oe_n = 1'b0;
                    d.cnt = 8'(READ_CYC);
                    d.st = ST_READ;
                end
            end
            ST_WRITE: begin
                if (q.cnt != 8'h00) begin
                    d.cnt = q.cnt - 8'h01;
                end else begin
                    d.pins = idle_pins(q.pins);
                    d.again = q.op == OP_SEM_ACQ;
                    d.phase_read = 1'b1;
                    if (q.op == OP_SEM_REL) d.owned = 1'b0;
                    d.cnt = is_flag(q.op) ? 8'(FLAG_REC_CYC) : 8'(GAP_CYC);
                    d.st = ST_RELEASE;
                end
            end
            ST_READ: begin
                if (q.cnt != 8'h00) begin
                    d.cnt = q.cnt - 8'h01;
                end else begin
                    d.pins = idle_pins(q.pins);
                    d.rdata = q.data_s2;
                    d.again = 1'b0;
                    d.cnt = 8'(GAP_CYC);
                    if (q.op == OP_SEM_ACQ) begin
                        if (!q.data_s2[0]) begin
                            d.owned = 1'b1;
                        end else if (q.abort) begin
                            d.op = OP_SEM_REL;
                            d.again = 1'b1;
                        end else begin
                            d.again = 1'b1;
                            d.cnt = 8'(FLAG_REC_CYC);
                        end
                    end
                    d.st = ST_RELEASE;
                end
            end
            ST_RELEASE: begin
                if (q.cnt != 8'h00) begin
                    d.cnt = q.cnt - 8'h01;
                end else if (q.again && !(q.abort && q.op != OP_SEM_ACQ && q.op != OP_SEM_REL)) begin
                    d.pins = select_pins(q.op, q.addr);
                    d.cnt = 8'(SETTLE_CYC);
                    d.st = ST_SELECT;
                end else begin
                    d.again = 1'b0;
                    d.done = 1'b1;
                    d.st = ST_IDLE;
                end
            end
            default: begin
                d.pins = idle_pins(q.pins);
                d.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            q <= '0;
            q.st <= ST_IDLE;
            q.op <= OP_NONE;
            q.int_en <= `CTRL_RESET;
            q.pins <= idle_pins('0);
            q.busy_sync <= '1;
            q.int_sync <= '1;
        end else begin
            q <= d;
        end
    end

endmodule // dpm_port_ctrl

// [dpm_port_ctrl_sva.sv]
// Purpose: Concurrent checks on the memory pins and bus answers of the port controller.
// Assumes: One clock domain; synchronous active-low reset.
// Notes: Attached to every controller instance by the bind at the foot.
`timescale 1ns/10ps
module dpm_port_ctrl_sva
    import dpm_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [1:0] s_bresp,
    input wire logic s_bvalid,
    input wire logic s_bready,
    input wire logic [31:0] s_rdata,
    input wire logic s_rvalid,
    input wire logic s_rready,
    input wire dpm_pins_s mem_pins,
    input wire dpm_in_s mem_in
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    chk_flag_without_ce: assert property (!mem_pins.flag_latch_select_n |-> mem_pins.ce_n)
        else $error("chip select low during flag access");
    chk_flag_addr_low: assert property (!mem_pins.flag_latch_select_n |-> mem_pins.addr[14:3] == 12'h000)
        else $error("upper address bits set during flag access");
    chk_flag_data_all: assert property (!mem_pins.flag_latch_select_n && mem_pins.data_oe
        |-> mem_pins.data_out inside {9'h000, 9'h1ff})
        else $error("flag write data lines differ");
    chk_write_after_busy: assert property (!mem_pins.ce_n && !mem_pins.rw_n |-> $past(mem_in.busy_n, 3))
        else $error("memory write started while busy");
    chk_drive_only_write: assert property (mem_pins.data_oe |-> !mem_pins.rw_n && mem_pins.oe_n)
        else $error("data bus driven outside a write");
    chk_flag_recovery: assert property ($rose(mem_pins.flag_latch_select_n) |-> mem_pins.flag_latch_select_n [*2])
        else $error("flag select gap too short");
    chk_bresp_hold: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
        else $error("write response dropped early");
    chk_rdata_hold: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
        else $error("read data dropped early");
    cover property (!mem_pins.flag_latch_select_n && !mem_pins.rw_n);
    cover property (!mem_pins.ce_n && !mem_in.busy_n);
    cover property ($rose(mem_in.int_n));
endmodule // dpm_port_ctrl_sva
bind dpm_port_ctrl dpm_port_ctrl_sva dpm_port_ctrl_sva_i (.clock, .rst_n, .s_bresp, .s_bvalid, .s_bready,
    .s_rdata, .s_rvalid, .s_rready, .mem_pins, .mem_in);

// [dpm_mem_model.sv]
// Purpose: Behavioural model of one port of the dual-port memory with mailbox, busy and flag latches.
// Assumes: The bench plays the opposite port through contend, other_send and other_holds.
// Notes: A released data bus shows a pattern that changes every cycle.
`timescale 1ns/10ps
module dpm_mem_model
    import dpm_pkg::*;
(
    input wire logic clock,
    input wire dpm_pins_s pins,
    input wire logic contend,
    input wire logic other_send,
    input wire logic [7:0] other_holds,
    output dpm_in_s mem_in
);
    logic [8:0] mem [16];
    logic [7:0] ours = 8'h00;
    logic [7:0] pend = 8'h00;
    logic int_q = 1'b0;
    logic [8:0] last = 9'h000;
    wire sel = !pins.flag_latch_select_n;
    wire [2:0] fa = pins.addr[2:0];
    wire wr_en = !pins.rw_n && pins.data_oe;
    always_comb begin
        mem_in.busy_n = !(contend && !pins.ce_n);
        mem_in.int_n = !int_q;
        mem_in.data_in = ~last;
        if (!pins.oe_n && pins.rw_n && sel)
            mem_in.data_in = {9{!ours[fa]}};
        else if (!pins.oe_n && pins.rw_n && !pins.ce_n)
            mem_in.data_in = mem[pins.addr[3:0]];
    end
    always @(posedge clock) begin
        last <= mem_in.data_in;
        if (other_send)
            {int_q, mem[14]} <= {1'b1, 9'h0c3};
        for (int i = 0; i < 8; i++)
            if (pend[i] && !other_holds[i]) {ours[i], pend[i]} <= 2'b10;
        if (wr_en && sel && !pins.data_out[0])
            {ours[fa], pend[fa]} <= other_holds[fa] ? 2'b01 : 2'b10;
        if (wr_en && sel && pins.data_out[0])
            {ours[fa], pend[fa]} <= 2'b00;
        if (wr_en && !pins.ce_n && mem_in.busy_n)
            mem[pins.addr[3:0]] <= pins.data_out;
        if (!pins.oe_n && !pins.ce_n && mem_in.busy_n && pins.addr == `DPM_MBOX_LEFT)
            int_q <= 1'b0;
    end
endmodule // dpm_mem_model

// [dual_port_arbitration_mailbox_semaphore_tb_top.sv]
// Purpose: Self-checking bench of the left port controller against the memory model.
// Assumes: Registers and op codes as in the parameter header.
// Notes: Bus transfers use one write and one read at a time.
`timescale 1ns/10ps
`include "dpm_params.svh"
module dual_port_arbitration_mailbox_semaphore_tb_top
    import dpm_pkg::*;
;
    logic clock, rst_n, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, s_awready, s_wready;
    logic s_bvalid, s_arready, s_rvalid, contend, other_send;
    logic [7:0] s_awaddr, s_araddr, other_holds;
    logic [31:0] s_wdata, s_rdata, st;
    logic [3:0] s_wstrb;
    logic [1:0] s_bresp, s_rresp;
    dpm_pins_s mem_pins;
    dpm_in_s mem_in;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    dpm_port_ctrl dpm_port_ctrl_i (.clock, .rst_n, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
        .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
        .s_rresp, .s_rvalid, .s_rready, .mem_pins, .mem_in);
    dpm_mem_model dpm_mem_model_i (.clock, .pins(mem_pins), .contend, .other_send, .other_holds, .mem_in);
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clock);
        {s_awaddr, s_wdata, s_wstrb} <= {a, d, 4'hf};
        {s_awvalid, s_wvalid, s_bready} <= 3'b111;
        fork
            begin do @(posedge clock); while (!s_awready); s_awvalid <= 1'b0; end
            begin do @(posedge clock); while (!s_wready); s_wvalid <= 1'b0; end
        join
        do @(posedge clock); while (!s_bvalid);
        s_bready <= 1'b0;
        check("bresp", s_bresp, er);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        {s_araddr, s_arvalid, s_rready} <= {a, 2'b11};
        do @(posedge clock); while (!s_arready);
        s_arvalid <= 1'b0;
        do @(posedge clock); while (!s_rvalid);
        d = s_rdata;
        s_rready <= 1'b0;
    endtask
    task automatic run(input logic [14:0] a, input logic [8:0] d, input logic [2:0] op);
        wr(`REG_ADDR, a, 2'h0);
        wr(`REG_WDATA, d, 2'h0);
        wr(`REG_CMD, op, 2'h0);
    endtask
    task automatic wait_done(output logic [31:0] s);
        s = 32'h0;
        while (!s[1]) rd(`REG_STATUS, s);
        wr(`REG_STATUS, 32'h2, 2'h0);
    endtask
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    initial begin
        {s_awaddr, s_awvalid, s_wdata, s_wstrb, s_wvalid, s_bready, s_araddr, s_arvalid, s_rready} = '0;
        {rst_n, contend, other_send, other_holds} = '0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        rd(`REG_STATUS, st);
        check("status reset", st, 32'h0);
        rd(8'h40, st);
        check("unmapped data", {s_rresp, st[29:0]}, {2'h2, 30'h0});
        wr(8'h40, 32'h1, 2'h2);
        wr(`REG_CMD, `OP_NONE, 2'h0);
        rd(`REG_STATUS, st);
        check("dropped", st[5], 1'b1);
        run(15'h0005, 9'h1a5, `OP_MEM_WR);
        wait_done(st);
        run(15'h0005, 9'h000, `OP_MEM_RD);
        wait_done(st);
        rd(`REG_RDATA, st);
        check("mem data", st, 32'h1a5);
        $display("test registers and memory done");
        wr(`REG_CTRL, 32'h1, 2'h0);
        @(posedge clock) other_send <= 1'b1;
        @(posedge clock) other_send <= 1'b0;
        run(15'h0000, 9'h05a, `OP_MBX_SEND);
        wait_done(st);
        run(`DPM_MBOX_RIGHT, 9'h000, `OP_MEM_RD);
        wait_done(st);
        rd(`REG_RDATA, st);
        check("sent mail", st, 32'h05a);
        rd(`REG_STATUS, st);
        check("int kept", st[3], 1'b1);
        run(15'h0000, 9'h000, `OP_MBX_READ);
        wait_done(st);
        rd(`REG_RDATA, st);
        check("own mail", st, 32'h0c3);
        rd(`REG_STATUS, st);
        check("int cleared", st[3], 1'b0);
        $display("test mailbox done");
        contend <= 1'b1;
        run(15'h0003, 9'h1c3, `OP_MEM_WR);
        repeat (60) @(posedge clock);
        @(posedge clock iff mem_pins.ce_n) contend <= 1'b0;
        wait_done(st);
        check("busy retry", {st[4], st[15:8] != 8'h00}, 2'b11);
        run(15'h0003, 9'h000, `OP_MEM_RD);
        wait_done(st);
        rd(`REG_RDATA, st);
        check("late write", st, 32'h1c3);
        $display("test busy done");
        run(15'h7ffb, 9'h000, `OP_SEM_ACQ);
        wait_done(st);
        check("owned", st[2], 1'b1);
        run(15'h0003, 9'h000, `OP_SEM_REL);
        wait_done(st);
        check("released", st[2], 1'b0);
        other_holds <= 8'h20;
        run(15'h0005, 9'h000, `OP_SEM_ACQ);
        repeat (80) @(posedge clock);
        rd(`REG_STATUS, st);
        check("polling", st[2:0], 3'b001);
        other_holds <= 8'h00;
        wait_done(st);
        check("handed over", st[2], 1'b1);
        $display("test flags done");
        tally_and_finish();
    end
endmodule // dual_port_arbitration_mailbox_semaphore_tb_top
